/* hdl/dct_pkg.sv */
// package: register map, field layout, reset values and carriers for the dram command timing block
package dct_pkg;
  // register byte addresses
  localparam logic [7:0] DCT_OFS_CFG_ONE = 8'h00;
  localparam logic [7:0] DCT_OFS_CFG_TWO = 8'h04;
  localparam logic [7:0] DCT_OFS_CAL_LAT = 8'h08;
  localparam logic [7:0] DCT_OFS_DLL_BYP = 8'h0C;
  localparam logic [7:0] DCT_OFS_STATUS  = 8'h10;
  // field positions in the second delay register
  localparam int DCT_POS_RBEND  = 28;
  localparam int DCT_POS_PRE2ACT = 24;
  localparam int DCT_POS_ACT2COL = 20;
  localparam int DCT_POS_ACT2ACT = 16;
  localparam int DCT_POS_WR2PRE = 12;
  localparam int DCT_POS_RD2PRE = 8;
  localparam int DCT_POS_PREALL = 0;
  // overflow bit of write-to-precharge in the first register
  localparam int DCT_POS_WR2PRE_OVF = 26;
  // calibration latency fields
  localparam int DCT_POS_PHYCLK = 4;
  localparam int DCT_POS_CAPCLK = 0;
  // dll bypass bit
  localparam int DCT_POS_DLLBYP = 24;
  // reset values
  localparam logic [31:0] DCT_RST_CFG_ONE = 32'h0000_0000;
  localparam logic [31:0] DCT_RST_CFG_TWO = 32'h0000_0000;
  localparam logic [3:0]  DCT_RST_PHYCLK  = 4'h4;
  localparam logic [3:0]  DCT_RST_CAPCLK  = 4'h3;
  localparam logic        DCT_RST_DLLBYP  = 1'b1;
  // writable masks
  localparam logic [31:0] DCT_MSK_CFG_TWO = 32'hFFFF_FF0F;
  localparam logic [31:0] DCT_MSK_CFG_ONE = 32'h0400_0000;
  localparam logic [31:0] DCT_MSK_CAL_LAT = 32'h0000_00FF;
  localparam logic [31:0] DCT_MSK_DLL_BYP = 32'h0100_0000;

  // command kinds from the scheduler
  typedef enum logic [2:0] {
    DCT_CMD_NOP, DCT_CMD_ACT, DCT_CMD_RD, DCT_CMD_WR, DCT_CMD_PRE, DCT_CMD_PREALL, DCT_CMD_REF
  } dct_cmd_e;

  // one command request
  typedef struct packed {
    logic     valid;
    dct_cmd_e kind;
    logic [2:0] bank;
  } dct_req_s;

  // phy delay settings
  typedef struct packed {
    logic [3:0] phyClkDly;
    logic [3:0] read_capture_clock_delay;
    logic       dllBypass;
  } dct_phy_s;
endpackage

/* hdl/dct_delay_counter.sv */
// one spacing counter: loads a minimum spacing and counts down to zero
`timescale 1ns/10ps
module dct_delay_counter #(
  parameter int WIDTH = 5
) (
  // clock and reset
  input  wire logic             clk_sys,
  input  wire logic             reset_n,
  // control
  input  wire logic             start,
  input  wire logic [WIDTH-1:0] loadValue,
  // state
  output logic                  busy
);
  logic [WIDTH-1:0] count_q;

  // a value of n blocks the n-1 cycles after the start cycle
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      count_q <= '0;
    else if (start)
      count_q <= (loadValue > 1) ? WIDTH'(loadValue - 1'b1) : '0;
    else if (count_q != '0)
      count_q <= WIDTH'(count_q - 1'b1);
  end

  assign busy = (count_q != '0);
endmodule // dct_delay_counter

/* hdl/dram_command_timing_delays.sv */
// dram command spacing enforcement with its delay, calibration and dll registers
//
// How it works
// - read burst busy for read-burst-end clocks
// - precharge to activate wait, same bank
// - activate to column wait, same bank
// - activate to activate wait, other bank
// - write to precharge wait, same bank
// - overflow bit extends write-to-precharge to five bits
// - read to precharge wait, same bank
// - precharge-all blocks activate and refresh
// - phy output clock delay, bits 7:4
// - read capture clock delay, bits 3:0
// - dll bypass bit 24 selects digital dll
// - unused bits ignore writes, read zero
`timescale 1ns/10ps
module dram_command_timing_delays #(
  parameter int NUM_BANKS = 8
) (
  // clock and reset
  input  wire logic              clk_sys,
  input  wire logic              reset_n,
  // register port
  input  wire logic [7:0]        regAddr,
  input  wire logic [31:0]       regWrData,
  input  wire logic              regWrite,
  input  wire logic              regRead,
  output logic [31:0]            regRdData,
  // scheduler request and grant
  input  dct_pkg::dct_req_s      cmdReq,
  output logic                   cmdGrant,
  output dct_pkg::dct_req_s      cmdIssued,
  // status and phy controls
  output logic                   readBurstBusy,
  output dct_pkg::dct_phy_s      phyCtrl
);
  import dct_pkg::*;

  logic [31:0] cfgTwo_q;
  logic [31:0] cfgOne_q;
  logic [7:0]  calLat_q;
  logic        dllByp_q;
  logic [31:0] regRdData_q;
  logic        cmdGrant_q;
  dct_req_s    cmdIssued_q;
  logic        readBurstBusy_q;
  dct_phy_s    phyCtrl_q;

  // field views
  logic [3:0] read_burst_end_delay;
  logic [3:0] pre2ActDly;
  logic [3:0] act2ColDly;
  logic [3:0] act2ActDly;
  logic [4:0] wr2PreDly;
  logic [3:0] rd2PreDly;
  logic [3:0] preAllDly;

  assign read_burst_end_delay   = cfgTwo_q[DCT_POS_RBEND +: 4];
  assign pre2ActDly = cfgTwo_q[DCT_POS_PRE2ACT +: 4];
  assign act2ColDly = cfgTwo_q[DCT_POS_ACT2COL +: 4];
  assign act2ActDly = cfgTwo_q[DCT_POS_ACT2ACT +: 4];
  assign wr2PreDly  = {cfgOne_q[DCT_POS_WR2PRE_OVF], cfgTwo_q[DCT_POS_WR2PRE +: 4]};
  assign rd2PreDly  = cfgTwo_q[DCT_POS_RD2PRE +: 4];
  assign preAllDly  = cfgTwo_q[DCT_POS_PREALL +: 4];

  // write strobe per register; one process per register keeps each concern apart
  logic wrCfgTwo;
  logic wrCfgOne;
  logic wrCalLat;
  logic wrDllByp;

  assign wrCfgTwo = regWrite && (regAddr == DCT_OFS_CFG_TWO);
  assign wrCfgOne = regWrite && (regAddr == DCT_OFS_CFG_ONE);
  assign wrCalLat = regWrite && (regAddr == DCT_OFS_CAL_LAT);
  assign wrDllByp = regWrite && (regAddr == DCT_OFS_DLL_BYP);

  // second delay register, all seven spacing fields
  // bits 7:4 dropped by the mask
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      cfgTwo_q <= DCT_RST_CFG_TWO;
    else if (wrCfgTwo)
      cfgTwo_q <= regWrData & DCT_MSK_CFG_TWO;
  end

  // first delay register; only the write-to-precharge overflow bit lives here
  // all other bits dropped
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      cfgOne_q <= DCT_RST_CFG_ONE;
    else if (wrCfgOne)
      cfgOne_q <= regWrData & DCT_MSK_CFG_ONE;
  end

  // calibration latency, reset to the recommended settings
  // phy output clock delay and read capture clock delay
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      calLat_q <= {DCT_RST_PHYCLK, DCT_RST_CAPCLK};
    else if (wrCalLat)
      calLat_q <= regWrData[7:0];
  end

  // dll bypass; zero is reserved, stored anyway and left to software to avoid
  // bypass bit stored
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      dllByp_q <= DCT_RST_DLLBYP;
    else if (wrDllByp)
      dllByp_q <= regWrData[DCT_POS_DLLBYP];
  end

  // read data one cycle after the strobe, zero elsewhere and for unmapped addresses
  // reads have no side effects, so polling any address is harmless
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      regRdData_q <= 32'h0000_0000;
    else if (regRead)
    begin
      case (regAddr)
        DCT_OFS_CFG_TWO: regRdData_q <= cfgTwo_q;
        DCT_OFS_CFG_ONE: regRdData_q <= cfgOne_q;
        DCT_OFS_CAL_LAT: regRdData_q <= {24'h00_0000, calLat_q};
        DCT_OFS_DLL_BYP: regRdData_q <= {7'h00, dllByp_q, 24'h00_0000};
        DCT_OFS_STATUS:  regRdData_q <= {31'h0000_0000, readBurstBusy_q};
        default:         regRdData_q <= 32'h0000_0000;
      endcase
    end
    else
      regRdData_q <= 32'h0000_0000;
  end

  // command decode of the issuing cycle
  // decoded straight from the request, so a refused command costs no state
  logic isAct;
  logic isRd;
  logic isWr;
  logic isPre;
  logic isPreAll;
  logic isRef;
  logic issue;

  assign isAct    = cmdReq.valid && (cmdReq.kind == DCT_CMD_ACT);
  assign isRd     = cmdReq.valid && (cmdReq.kind == DCT_CMD_RD);
  assign isWr     = cmdReq.valid && (cmdReq.kind == DCT_CMD_WR);
  assign isPre    = cmdReq.valid && (cmdReq.kind == DCT_CMD_PRE);
  assign isPreAll = cmdReq.valid && (cmdReq.kind == DCT_CMD_PREALL);
  assign isRef    = cmdReq.valid && (cmdReq.kind == DCT_CMD_REF);

  // per-bank and shared busy flags
  logic [NUM_BANKS-1:0] pre2ActBusy;
  logic [NUM_BANKS-1:0] act2ColBusy;
  logic [NUM_BANKS-1:0] wr2PreBusy;
  logic [NUM_BANKS-1:0] rd2PreBusy;
  logic [NUM_BANKS-1:0] bankSel;
  logic                 act2ActBusy;
  logic                 preAllBusy;
  logic                 rbEndBusy;
  logic [2:0]           lastActBank_q;

  // per-bank spacing counters, started only by granted commands
  // a counter loaded with n holds off its command for n-1 cycles after the
  // issuing cycle, so that command is allowed exactly n cycles after issue
  // counters begin at issue
  genvar gb;
  generate
    for (gb = 0; gb < NUM_BANKS; gb++)
    begin : g_bank
      assign bankSel[gb] = (cmdReq.bank == 3'(gb));
      dct_delay_counter #(.WIDTH(5)) u_pre2act (
        .clk_sys   (clk_sys),
        .reset_n   (reset_n),
        .start     (issue && ((isPre && bankSel[gb]) || isPreAll)),
        .loadValue ({1'b0, pre2ActDly}),
        .busy      (pre2ActBusy[gb])
      );
      dct_delay_counter #(.WIDTH(5)) u_act2col (
        .clk_sys   (clk_sys),
        .reset_n   (reset_n),
        .start     (issue && isAct && bankSel[gb]),
        .loadValue ({1'b0, act2ColDly}),
        .busy      (act2ColBusy[gb])
      );
      // write to precharge, five bit count
      // the overflow bit lets this reach 31 clocks
      dct_delay_counter #(.WIDTH(5)) u_wr2pre (
        .clk_sys   (clk_sys),
        .reset_n   (reset_n),
        .start     (issue && isWr && bankSel[gb]),
        .loadValue (wr2PreDly),
        .busy      (wr2PreBusy[gb])
      );
      dct_delay_counter #(.WIDTH(5)) u_rd2pre (
        .clk_sys   (clk_sys),
        .reset_n   (reset_n),
        .start     (issue && isRd && bankSel[gb]),
        .loadValue ({1'b0, rd2PreDly}),
        .busy      (rd2PreBusy[gb])
      );
    end
  endgenerate

  // activate spacing, checked only for another bank
  // one chip select here, so one counter serves every bank
  dct_delay_counter #(.WIDTH(5)) u_act2act (
    .clk_sys   (clk_sys),
    .reset_n   (reset_n),
    .start     (issue && isAct),
    .loadValue ({1'b0, act2ActDly}),
    .busy      (act2ActBusy)
  );

  dct_delay_counter #(.WIDTH(5)) u_preall (
    .clk_sys   (clk_sys),
    .reset_n   (reset_n),
    .start     (issue && isPreAll),
    .loadValue ({1'b0, preAllDly}),
    .busy      (preAllBusy)
  );

  // read burst end window
  // a read during a burst restarts the count, so the window covers the latest burst
  dct_delay_counter #(.WIDTH(5)) u_rbend (
    .clk_sys   (clk_sys),
    .reset_n   (reset_n),
    .start     (issue && isRd),
    .loadValue ({1'b0, read_burst_end_delay}),
    .busy      (rbEndBusy)
  );

  // last activated bank, used to tell same-bank from other-bank activates
  // only the latest activate is kept: any older one restarted the same counter
  // earlier, so it can never be the binding constraint
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      lastActBank_q <= 3'h0;
    else if (issue && isAct)
      lastActBank_q <= cmdReq.bank;
  end

  // grant decision; a blocked command is simply held off, the scheduler retries.
  // a held request is granted again on every allowed cycle, so the scheduler
  // must drop or change its request in the cycle after the grant
  logic actBlocked;
  logic refBlocked;
  logic colBlocked;
  logic preBlocked;
  logic preAllBlocked;
  logic allowed;

  // activate and refresh wait on precharge-all
  // another bank waits on the last activate
  assign actBlocked    = pre2ActBusy[cmdReq.bank] || preAllBusy
                         || (act2ActBusy && (cmdReq.bank != lastActBank_q));
  assign refBlocked    = preAllBusy;
  assign colBlocked    = act2ColBusy[cmdReq.bank];
  assign preBlocked    = wr2PreBusy[cmdReq.bank] || rd2PreBusy[cmdReq.bank];
  // precharge-all must respect every bank's write and read recovery
  assign preAllBlocked = (|wr2PreBusy) || (|rd2PreBusy);

  // only the blocking term of the requested kind counts
  always_comb
  begin
    allowed = 1'b1;
    if (isAct && actBlocked)
      allowed = 1'b0;
    if (isRef && refBlocked)
      allowed = 1'b0;
    if ((isRd || isWr) && colBlocked)
      allowed = 1'b0;
    if (isPre && preBlocked)
      allowed = 1'b0;
    if (isPreAll && preAllBlocked)
      allowed = 1'b0;
  end

  assign issue = cmdReq.valid && allowed;

  // registered grant and issued command; zero spacing gives back-to-back issue
  // an idle cycle shows an all-zero no-op, never a stale copy
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cmdGrant_q  <= 1'b0;
      cmdIssued_q <= '{valid: 1'b0, kind: DCT_CMD_NOP, bank: 3'h0};
    end
    else
    begin
      cmdGrant_q  <= issue;
      cmdIssued_q <= issue ? cmdReq : '{valid: 1'b0, kind: DCT_CMD_NOP, bank: 3'h0};
    end
  end

  // burst busy flag follows the counter plus the issuing cycle
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      readBurstBusy_q <= 1'b0;
    else
      readBurstBusy_q <= (issue && isRd && (read_burst_end_delay != 4'h0)) || rbEndBusy;
  end

  // phy controls, registered copies of the settings
  // the phy sees a write one cycle late; software should only change these
  // while the memory interface is idle
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      phyCtrl_q <= '{phyClkDly: DCT_RST_PHYCLK, read_capture_clock_delay: DCT_RST_CAPCLK, dllBypass: DCT_RST_DLLBYP};
    else
    begin
      phyCtrl_q.phyClkDly <= calLat_q[DCT_POS_PHYCLK +: 4];
      phyCtrl_q.read_capture_clock_delay <= calLat_q[DCT_POS_CAPCLK +: 4];
      // digital dll selected by bypass bit
      phyCtrl_q.dllBypass <= dllByp_q;
    end
  end

  // every output is a flop, so no request path reaches a pin combinationally
  assign regRdData     = regRdData_q;
  assign cmdGrant      = cmdGrant_q;
  assign cmdIssued     = cmdIssued_q;
  assign readBurstBusy = readBurstBusy_q;
  assign phyCtrl       = phyCtrl_q;
endmodule // dram_command_timing_delays

/* test/dct_props.sv */
// checker: grant, spacing and phy setting assertions for the command timing block
`timescale 1ns/10ps
module dct_props
  import dct_pkg::*;
(
  // clock and reset
  input wire logic              clk_sys,
  input wire logic              reset_n,
  // register port
  input wire logic [7:0]        regAddr,
  input wire logic [31:0]       regWrData,
  input wire logic              regWrite,
  input wire logic              regRead,
  input wire logic [31:0]       regRdData,
  // command path and phy
  input wire dct_pkg::dct_req_s cmdReq,
  input wire logic              cmdGrant,
  input wire dct_pkg::dct_req_s cmdIssued,
  input wire dct_pkg::dct_phy_s phyCtrl
);
  logic [31:0] cfgTwo_q;
  logic        ovf_q;
  logic [4:0]  actCnt_q;
  logic [4:0]  wrCnt_q;
  logic [2:0]  actBank_q;
  logic [2:0]  wrBank_q;
  wire isAct = cmdIssued.valid && cmdIssued.kind == DCT_CMD_ACT;
  wire isWr  = cmdIssued.valid && cmdIssued.kind == DCT_CMD_WR;
  wire isCol = cmdIssued.valid && cmdIssued.kind inside {DCT_CMD_RD, DCT_CMD_WR};

  // shadow of the delay fields, updated on the same edge as the block
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cfgTwo_q <= '0;
      ovf_q    <= 1'b0;
    end
    else if (regWrite && regAddr == DCT_OFS_CFG_TWO)
      cfgTwo_q <= regWrData;
    else if (regWrite && regAddr == DCT_OFS_CFG_ONE)
      ovf_q <= regWrData[DCT_POS_WR2PRE_OVF];
  end

  // cycles since last activate and write; saturate so old history never constrains
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      actCnt_q  <= 5'h1f;
      wrCnt_q   <= 5'h1f;
      actBank_q <= 3'h0;
      wrBank_q  <= 3'h0;
    end
    else
    begin
      actCnt_q <= isAct ? 5'h01 : actCnt_q + {4'h0, actCnt_q != 5'h1f};
      wrCnt_q  <= isWr ? 5'h01 : wrCnt_q + {4'h0, wrCnt_q != 5'h1f};
      if (isAct)
        actBank_q <= cmdIssued.bank;
      if (isWr)
        wrBank_q <= cmdIssued.bank;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  chk_issue_copy: assert property (cmdGrant |-> $past(cmdReq.valid) && cmdIssued == $past(cmdReq))
    else $error("issued command differs from request");
  chk_idle_zero: assert property (!cmdGrant |-> cmdIssued == '0)
    else $error("issued command without grant");
  chk_act_to_col: assert property (isCol && cmdIssued.bank == actBank_q |-> actCnt_q >= cfgTwo_q[23:20])
    else $error("column command too soon after activate");
  chk_act_to_act: assert property (isAct && cmdIssued.bank != actBank_q |-> actCnt_q >= cfgTwo_q[19:16])
    else $error("activate too soon after other bank activate");
  chk_wr_to_pre: assert property (cmdIssued.valid && (cmdIssued.kind == DCT_CMD_PREALL
      || (cmdIssued.kind == DCT_CMD_PRE && cmdIssued.bank == wrBank_q)) |-> wrCnt_q >= {ovf_q, cfgTwo_q[15:12]})
    else $error("precharge too soon after write");
  chk_phy_follow: assert property (regWrite && regAddr == DCT_OFS_CAL_LAT |->
      ##2 {phyCtrl.phyClkDly, phyCtrl.read_capture_clock_delay} == $past(regWrData[7:0], 2))
    else $error("phy delays do not follow register");
  chk_dll_follow: assert property (regWrite && regAddr == DCT_OFS_DLL_BYP |->
      ##2 phyCtrl.dllBypass == $past(regWrData[DCT_POS_DLLBYP], 2))
    else $error("dll bypass does not follow register");
  chk_unused_zero: assert property ($past(regRead) && $past(regAddr) == DCT_OFS_DLL_BYP |->
      (regRdData & ~DCT_MSK_DLL_BYP) == 32'h0000_0000)
    else $error("unused dll bits read nonzero");
endmodule // dct_props

bind dram_command_timing_delays dct_props u_dct_props (
  .clk_sys(clk_sys), .reset_n(reset_n), .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite),
  .regRead(regRead), .regRdData(regRdData), .cmdReq(cmdReq), .cmdGrant(cmdGrant), .cmdIssued(cmdIssued),
  .phyCtrl(phyCtrl)
);

/* test/dct_dram_model.sv */
// partner model: dram banks tracking open rows and flagging illegal accesses
`timescale 1ns/10ps
module dct_dram_model
  import dct_pkg::*;
(
  // clock and reset
  input  wire logic              clk_sys,
  input  wire logic              reset_n,
  // commands from the controller
  input  wire dct_pkg::dct_req_s cmdIssued,
  // model status
  output logic                   protoErr_q
);
  logic [7:0] rowOpen_q;

  // column access to a closed bank or refresh with rows open would lose data
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rowOpen_q  <= 8'h00;
      protoErr_q <= 1'b0;
    end
    else if (cmdIssued.valid)
    begin
      case (cmdIssued.kind)
        DCT_CMD_ACT:            rowOpen_q[cmdIssued.bank] <= 1'b1;
        DCT_CMD_PRE:            rowOpen_q[cmdIssued.bank] <= 1'b0;
        DCT_CMD_PREALL:         rowOpen_q <= 8'h00;
        DCT_CMD_REF:            protoErr_q <= protoErr_q | (rowOpen_q != 8'h00);
        DCT_CMD_RD, DCT_CMD_WR: protoErr_q <= protoErr_q | !rowOpen_q[cmdIssued.bank];
        default:                ;
      endcase
    end
  end
endmodule // dct_dram_model

/* test/dram_command_timing_delays_test.sv */
// testbench: registers, command spacing and burst timing of the command timing block
`timescale 1ns/10ps
module dram_command_timing_delays_test;
  import dct_pkg::*;
  logic        clk_sys = 1'b0;
  logic        reset_n, regWrite, regRead, cmdGrant, readBurstBusy, rdPend, ovf, protoErr;
  logic [7:0]  regAddr;
  logic [31:0] regWrData, regRdData, cfg, seed, cyc = 0, gQ[$], rdQ[$];
  dct_req_s    cmdReq, cmdIssued;
  dct_phy_s    phyCtrl;
  int          errors = 0, checksDone = 0, busyCnt;
  logic [7:0]  ofs[5] = '{DCT_OFS_CFG_ONE, DCT_OFS_CFG_TWO, DCT_OFS_CAL_LAT, DCT_OFS_DLL_BYP, 8'h14};
  logic [31:0] msk[5] = '{DCT_MSK_CFG_ONE, DCT_MSK_CFG_TWO, DCT_MSK_CAL_LAT, DCT_MSK_DLL_BYP, 32'h0};

  always #20 clk_sys = ~clk_sys;

  dram_command_timing_delays dut (.clk_sys(clk_sys), .reset_n(reset_n), .regAddr(regAddr), .regWrData(regWrData),
    .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData), .cmdReq(cmdReq), .cmdGrant(cmdGrant),
    .cmdIssued(cmdIssued), .readBurstBusy(readBurstBusy), .phyCtrl(phyCtrl));
  dct_dram_model u_dram (.clk_sys(clk_sys), .reset_n(reset_n), .cmdIssued(cmdIssued), .protoErr_q(protoErr));

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checksDone++;
    if (seen !== exp)
    begin
      errors++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", checksDone, errors);
    if (errors == 0 && checksDone > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // one strobe cycle then a quiet cycle, so no strobe is assigned twice per edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    regWrite <= 1'b1; regAddr <= a; regWrData <= d;
    @(posedge clk_sys);
    regWrite <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    regRead <= 1'b1; regAddr <= a; rdQ.push_back(exp);
    @(posedge clk_sys);
    regRead <= 1'b0;
    @(posedge clk_sys);
  endtask

  // hold a request exactly until the cycle it should be taken; an early grant shows as a cycle mismatch
  task automatic cmd(input dct_cmd_e k, input logic [2:0] b, input int hold);
    cmdReq <= '{1'b1, k, b};
    gQ.push_back({k, b, 26'(cyc + hold + 1)});
    repeat (hold) @(posedge clk_sys);
  endtask

  task automatic idle;
    cmdReq <= '0;
    repeat (40) @(posedge clk_sys);
  endtask

  function automatic int g(input int n);
    return (n < 1) ? 1 : n;
  endfunction

  // cycle count and hang guard
  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    if (cyc == 32'd8000)
    begin
      errors++;
      tally_and_finish;
    end
  end

  // monitor: compare each appearing result with the oldest note
  always @(posedge clk_sys)
  begin
    if (rdPend)
      check("read data", regRdData, rdQ.pop_front());
    rdPend = regRead;
    if (cmdGrant === 1'b1)
      check("grant", {cmdIssued.kind, cmdIssued.bank, cyc[25:0]}, gQ.size() ? gQ.pop_front() : '1);
    if (readBurstBusy === 1'b1)
      busyCnt++;
  end

  initial
  begin
    seed = 32'h5d9699e7; reset_n = 1'b0; rdPend = 1'b0;
    regAddr = 8'h00; regWrData = 32'h0000_0000; regWrite = 1'b0; regRead = 1'b0; cmdReq = '0;
    repeat (16) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(posedge clk_sys);
    check("phy controls", 32'(phyCtrl), 32'h0000_0087);
    rd(DCT_OFS_CAL_LAT, 32'h0000_0043);
    rd(DCT_OFS_STATUS, 32'h0000_0000);
    // all ones then read back: only writable bits stick, unmapped reads zero
    for (int i = 0; i < 5; i++)
    begin
      rd(ofs[i], (i == 2) ? 32'h0000_0043 : (i == 3) ? 32'h0100_0000 : 32'h0000_0000);
      wr(ofs[i], 32'hFFFF_FFFF);
      rd(ofs[i], msk[i]);
    end
    wr(DCT_OFS_DLL_BYP, 32'h0100_0000);
    wr(DCT_OFS_CAL_LAT, 32'h0000_0043);
    $display("register test done");
    // zero fields, full fields, then random fields
    for (int it = 0; it < 8; it++)
    begin
      cfg = (it == 0) ? 32'h0 : (it == 1) ? 32'hFFFF_FFFF : $random(seed);
      ovf = (it == 1) ? 1'b1 : (it == 0) ? 1'b0 : cfg[5];
      wr(DCT_OFS_CFG_TWO, cfg);
      wr(DCT_OFS_CFG_ONE, {5'h00, ovf, 26'h0});
      busyCnt = 0;
      cmd(DCT_CMD_ACT, 3'd0, 1); cmd(DCT_CMD_WR, 3'd0, g(cfg[23:20])); idle;
      cmd(DCT_CMD_ACT, 3'd1, 1); cmd(DCT_CMD_ACT, 3'd2, g(cfg[19:16])); idle;
      cmd(DCT_CMD_PRE, 3'd3, 1); cmd(DCT_CMD_ACT, 3'd3, g(cfg[27:24])); idle;
      cmd(DCT_CMD_ACT, 3'd4, 1); cmd(DCT_CMD_RD, 3'd4, g(cfg[23:20])); cmd(DCT_CMD_PRE, 3'd4, g(cfg[11:8])); idle;
      cmd(DCT_CMD_ACT, 3'd5, 1); cmd(DCT_CMD_WR, 3'd5, g(cfg[23:20])); cmd(DCT_CMD_PRE, 3'd5, g({ovf, cfg[15:12]}));
      idle;
      cmd(DCT_CMD_PREALL, 3'd0, 1); cmd(DCT_CMD_REF, 3'd0, g(cfg[3:0])); cmd(DCT_CMD_PREALL, 3'd0, 1);
      cmd(DCT_CMD_ACT, 3'd6, g((cfg[3:0] > cfg[27:24]) ? cfg[3:0] : cfg[27:24])); idle;
      check("burst cycles", busyCnt, 32'(cfg[31:28]));
      check("row protocol", 32'(protoErr), 32'h0000_0000);
      $display("spacing pass %0d done", it);
    end
    check("pending grants", gQ.size(), 32'h0000_0000);
    tally_and_finish;
  end
endmodule // dram_command_timing_delays_test
